// file: common/pc_stack_pkg.sv
/*
  Shared constants and types for the program flow unit: register
  indices, field positions, reset values and the carrier structs.
  Assumes an APB master with 32-bit data and one word per register.
*/
package pc_stack_pkg;
  localparam int PC_W = 13;
  localparam int TGT_W = 11;
  localparam int IDX_W = 9;
  localparam int ADDR_W = 11;
  localparam int DEPTH = 8;
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_INDIRECT = 9'h000;
  localparam logic [IDX_W-1:0] IDX_PC_LOW = 9'h002;
  localparam logic [IDX_W-1:0] IDX_BANK = 9'h003;
  localparam logic [IDX_W-1:0] IDX_POINTER = 9'h004;
  localparam logic [IDX_W-1:0] IDX_LATCH = 9'h00A;
  localparam logic [IDX_W-1:0] IDX_RESET_CAUSE = 9'h08E;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 9'h0F0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 9'h0F1;
  // Field positions.
  localparam int LATCH_W = 5;
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;
  localparam int BANK_BIT = 7;
  localparam int POWER_ON_BIT = 1;
  localparam int BROWNOUT_BIT = 0;
  localparam int EV_W = 3;
  localparam int EV_BROWNOUT = 0;
  localparam int EV_WATCHDOG = 1;
  localparam int EV_EXTERNAL = 2;
  // Reset values.
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] INT_VECTOR_DEFAULT = 13'h0004;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [EV_W-1:0] EV_ZERO = 3'h0;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [3:0] {
    REG_NONE, REG_INDIRECT, REG_PC_LOW, REG_BANK, REG_POINTER,
    REG_LATCH, REG_RESET_CAUSE, REG_IRQ_STATUS, REG_IRQ_MASK
  } reg_id_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic fetch;
    logic jump;
    logic call;
    logic ret;
    logic irq;
    logic [TGT_W-1:0] target;
  } core_op_t;
endpackage

// file: dv/file_model.sv
/*
  Behavioural register file of the core, reached through the pointer.
  Assumes one read or write strobe at a time from the flow unit.
*/
`timescale 1ns/1ns
module file_model
  import pc_stack_pkg::*;
(
  input wire logic clk,
  input wire logic [IDX_W-1:0] file_addr,
  input wire logic file_rd,
  input wire logic file_wr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [0:511];
  logic [7:0] last = 8'h00;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Writes land at the addressed cell, bank bit included.
  always @(posedge clk) begin
    if (file_wr) mem[file_addr] <= file_wdata;
    if (file_rd) last <= mem[file_addr];
  end
  // Off a read the data lines show no stale value, so nothing passes
  // by luck.
  assign file_rdata = file_rd ? mem[file_addr] : ~last;
endmodule

// file: dv/pc_stack_unit_props.sv
/*
  Port checker for the program flow unit.
  Assumes the unit's ports and package types; bound below.
*/
`timescale 1ns/1ns
module pc_stack_unit_props
  import pc_stack_pkg::*;
#(
  parameter logic [PC_W-1:0] INT_VECTOR = INT_VECTOR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire apb_req_t apb_in,
  input wire core_op_t core_op,
  input wire logic [PC_W-1:0] pc,
  input wire logic file_wr,
  input wire logic [IDX_W-1:0] file_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic [IDX_W-1:0] idx;
  assign acc = apb_in.psel && apb_in.penable;
  assign idx = apb_in.paddr[10:2];
  sequence s_call;
    core_op.call && !core_op.ret && !core_op.irq;
  endsequence
  sequence s_irq;
    core_op.irq && !core_op.ret;
  endsequence
  a_fetch_step: assert property (core_op.fetch && !core_op.jump &&
    !core_op.call && !core_op.ret && !core_op.irq |=>
    pc == $past(pc) + 13'h0001) else $error("pc did not step");
  a_jump_page: assert property (core_op.jump && !core_op.ret &&
    !core_op.irq |=> pc[10:0] == $past(core_op.target) && !pc[12])
    else $error("jump address wrong");
  a_call_return: assert property (s_call ##1 core_op.ret |=>
    pc == $past(pc, 2) + 13'h0001) else $error("call return wrong");
  a_irq_vector: assert property (s_irq |=> pc == INT_VECTOR)
    else $error("vector not taken");
  a_irq_return: assert property (s_irq ##1 core_op.ret |=>
    pc == $past(pc, 2)) else $error("interrupt return wrong");
  a_self_write: assert property (acc && apb_in.pwrite &&
    idx == IDX_INDIRECT && file_addr == 9'h000 |-> !file_wr)
    else $error("write through itself");
  a_write_target: assert property (file_wr |-> acc &&
    apb_in.pwrite && idx == IDX_INDIRECT) else $error("stray write");
  a_low_write: assert property (acc && apb_in.pwrite &&
    idx == IDX_PC_LOW && core_op == '0 |=>
    pc[7:0] == $past(apb_in.pwdata[7:0])) else $error("low byte lost");
endmodule
bind pc_stack_unit pc_stack_unit_props #(.INT_VECTOR(INT_VECTOR))
  pc_stack_unit_props_inst (.clk(clk), .rst_n(rst_n), .apb_in(apb_in),
  .core_op(core_op), .pc(pc), .file_wr(file_wr), .file_addr(file_addr));

// file: dv/tb_pc_stack_unit.sv
/*
  Self-checking bench of the program flow unit with a file model.
  Assumes zero-wait APB answers are waited for, never counted on.
*/
`timescale 1ns/1ns
module tb_pc_stack_unit
  import pc_stack_pkg::*;
;
  localparam logic [4:0] K_FETCH = 5'h10;
  localparam logic [4:0] K_JUMP = 5'h08;
  localparam logic [4:0] K_CALL = 5'h04;
  localparam logic [4:0] K_RET = 5'h02;
  localparam logic [4:0] K_IRQ = 5'h01;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_t apb_in = '0;
  core_op_t core_op = '0;
  logic ext_rst = 1'b0;
  logic wdog = 1'b0;
  logic bor = 1'b0;
  logic bor_en = 1'b1;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, irq, file_rd, file_wr, err;
  logic [PC_W-1:0] pc;
  logic [IDX_W-1:0] file_addr;
  logic [7:0] file_wdata, file_rdata;
  int num_errors = 0;
  int checks = 0;
  always #25 clk = ~clk;
  pc_stack_unit pc_stack_unit_inst (.clk(clk), .rst_n(rst_n),
    .apb_in(apb_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_op(core_op), .pc(pc), .external_master_reset(ext_rst),
    .watchdog_timer(wdog), .brownout_reset(bor),
    .brownout_detect_enable(bor_en), .file_addr(file_addr),
    .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata),
    .file_rdata(file_rdata), .irq(irq));
  file_model file_model_inst (.clk(clk), .file_addr(file_addr),
    .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata),
    .file_rdata(file_rdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [8:0] i,
                     input logic [7:0] d);
    int n;
    n = 0;
    apb_in <= '{1'b1, 1'b0, w, {i, 2'b00}, {24'h000000, d}};
    @(posedge clk);
    apb_in.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) num_errors++;
    rd = prdata;
    err = pslverr;
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
    @(posedge clk);
  endtask
  // The pc check waits for the falling edge so the update has landed.
  task automatic op(input core_op_t v, input logic [12:0] e);
    core_op <= v;
    @(posedge clk);
    fork
      begin
        @(negedge clk);
        chk({19'h00000, pc}, {19'h00000, e});
      end
    join_none
  endtask
  task automatic pulse(input logic [2:0] pins);
    {ext_rst, wdog, bor} <= pins;
    repeat (3) @(posedge clk);
    {ext_rst, wdog, bor} <= 3'b000;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_pc;
    bus(1'b1, IDX_LATCH, 8'h1F);
    bus(1'b1, IDX_PC_LOW, 8'hA5);
    op('0, 13'h1FA5);
    bus(1'b0, IDX_PC_LOW, 8'h00);
    chk(rd, 32'h000000A5);
    bus(1'b1, IDX_LATCH, 8'h18);
    op({K_JUMP, 11'h123}, 13'h0923);
    op({K_FETCH, 11'h000}, 13'h0924);
    op('0, 13'h0924);
  endtask
  task automatic t_stack;
    logic [12:0] push [9];
    bus(1'b1, IDX_LATCH, 8'h10);
    op({K_JUMP, 11'h100}, 13'h0100);
    for (int k = 0; k < 9; k++) begin
      push[k] = (k == 0) ? 13'h0101 : 13'h0200 + 13'(k);
      op({K_CALL, 11'h200 + 11'(k)}, 13'h0200 + 13'(k));
    end
    for (int k = 8; k > 0; k--) op({K_RET, 11'h000}, push[k]);
    op({K_RET, 11'h000}, push[8]);
    op({K_IRQ, 11'h000}, INT_VECTOR_DEFAULT);
    op({K_RET, 11'h000}, push[8]);
    op('0, push[8]);
    bus(1'b0, IDX_LATCH, 8'h00);
    chk(rd, 32'h00000010);
  endtask
  task automatic t_ind;
    bus(1'b1, IDX_POINTER, 8'h05);
    bus(1'b1, IDX_INDIRECT, 8'h3C);
    bus(1'b0, IDX_INDIRECT, 8'h00);
    chk(rd, 32'h0000003C);
    bus(1'b1, IDX_BANK, 8'h80);
    bus(1'b1, IDX_INDIRECT, 8'h5A);
    chk({24'h000000, file_model_inst.mem[9'h105]}, 32'h0000005A);
    bus(1'b1, IDX_BANK, 8'h00);
    bus(1'b1, IDX_POINTER, 8'h00);
    bus(1'b1, IDX_INDIRECT, 8'h77);
    chk({24'h000000, file_model_inst.mem[9'h000]}, 32'h00000000);
    bus(1'b0, IDX_INDIRECT, 8'h00);
    chk(rd, 32'h00000000);
    bus(1'b0, 9'h001, 8'h00);
    chk({31'h00000000, err}, 32'h00000001);
  endtask
  task automatic t_cause;
    bus(1'b1, IDX_RESET_CAUSE, 8'h03);
    bus(1'b1, IDX_IRQ_MASK, 8'h07);
    pulse(3'b010);
    op('0, 13'h0000);
    bus(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk(rd, 32'h00000002);
    bus(1'b0, IDX_RESET_CAUSE, 8'h00);
    chk(rd, 32'h00000003);
    pulse(3'b001);
    pulse(3'b100);
    bus(1'b1, IDX_IRQ_MASK, 8'h01);
    @(negedge clk);
    chk({31'h00000000, irq}, 32'h00000001);
    @(posedge clk);
    bus(1'b0, IDX_RESET_CAUSE, 8'h00);
    chk(rd, 32'h00000002);
    bus(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk(rd, 32'h00000005);
    @(negedge clk);
    chk({31'h00000000, irq}, 32'h00000000);
    @(posedge clk);
    bus(1'b1, IDX_RESET_CAUSE, 8'h03);
    bor_en <= 1'b0;
    repeat (2) @(posedge clk);
    pulse(3'b001);
    bus(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk(rd, 32'h00000000);
    bus(1'b0, IDX_RESET_CAUSE, 8'h00);
    chk(rd, 32'h00000003);
  endtask
  task automatic test_done;
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, IDX_RESET_CAUSE, 8'h00);
    chk(rd, 32'h00000000);
    t_pc;
    t_stack;
    t_ind;
    t_cause;
    test_done;
  end
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    test_done;
  end
endmodule

// file: hdl/pc_stack_unit.sv
/*
  Program counter, upper-address latch, return stack, indirect access
  and reset-cause flags of a small 8-bit core, as an APB slave.
  Assumes the decoder issues at most one flow operation per cycle and
  that reset-cause inputs are asynchronous levels held two cycles.
*/
// How it works
// R1: Thirteen-bit counter, low byte read/write.
// R2: Upper counter bits change only via latch; here fetch carries, returns, interrupts and jump target bits also change them.
// R3: Low-byte write loads upper bits from latch.
// R4: Jumps take eleven bits plus latch page.
// R5: Software sets page bits before jump or call.
// R6: Call and interrupt push full counter.
// R7: Returns pop stack top into counter.
// R8: Eight-deep stack, pointer hidden from software.
// R9: Push and pop leave latch untouched.
// R10: Stack wraps silently, ninth overwrites first.
// R11: Latch bit four ignored for paging.
// R12: Indirect location acts on pointed register.
// R13: Indirect read through itself returns zero.
// R14: Indirect write through itself changes nothing.
// R15: Effective address is bank bit plus pointer.
// R16: Flag separates power-on from other resets.
// R17: Brown-out flag cleared by brown-out reset.
// R18: Brown-out flag meaningless when detection off.
// R19: Counter steps per fetch; call pushes next.
`timescale 1ns/1ns
module pc_stack_unit
  import pc_stack_pkg::*;
#(
  parameter int STACK_DEPTH = DEPTH,
  parameter logic [PC_W-1:0] INT_VECTOR = INT_VECTOR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire apb_req_t apb_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire core_op_t core_op,
  output logic [PC_W-1:0] pc,
  input wire logic external_master_reset,
  input wire logic watchdog_timer,
  input wire logic brownout_reset,
  input wire logic brownout_detect_enable,
  output logic [IDX_W-1:0] file_addr,
  output logic file_rd,
  output logic file_wr,
  output logic [7:0] file_wdata,
  input wire logic [7:0] file_rdata,
  output logic irq
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  initial begin
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin
      $error("STACK_DEPTH must be a power of two of at least two");
    end
  end

  function automatic reg_id_t decode(input logic [IDX_W-1:0] a);
    case (a)
      IDX_INDIRECT: decode = REG_INDIRECT;
      IDX_PC_LOW: decode = REG_PC_LOW;
      IDX_BANK: decode = REG_BANK;
      IDX_POINTER: decode = REG_POINTER;
      IDX_LATCH: decode = REG_LATCH;
      IDX_RESET_CAUSE: decode = REG_RESET_CAUSE;
      IDX_IRQ_STATUS: decode = REG_IRQ_STATUS;
      IDX_IRQ_MASK: decode = REG_IRQ_MASK;
      default: decode = REG_NONE;
    endcase
  endfunction

  logic [LATCH_W-1:0] upper_address_latch;
  logic [7:0] pointer_register;
  logic indirect_bank_select;
  logic power_on_flag;
  logic brownout_reset_flag;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] read_clear;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] stack_ptr;

  // Synchronisers: stage one feeds stage two only.
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [EV_W-1:0] ev_prev;
  logic [EV_W-1:0] ev_rise;
  logic bod_enabled;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      ev_prev <= EV_ZERO;
    end else begin
      sync_a <= {brownout_detect_enable, external_master_reset,
                 watchdog_timer, brownout_reset};
      sync_b <= sync_a;
      ev_prev <= sync_b[EV_W-1:0];
    end
  end

  assign bod_enabled = sync_b[3];
  // A brown-out edge counts only while detection is enabled.
  assign ev_rise = (sync_b[EV_W-1:0] & ~ev_prev) &
                   {2'b11, bod_enabled}; // see R18
  logic core_reset;
  assign core_reset = |ev_rise;

  // Bus decode.
  logic setup;
  logic access;
  logic direct_ok;
  logic [IDX_W-1:0] eff_addr;
  reg_id_t direct_id;
  reg_id_t ind_id;
  reg_id_t target_id;
  logic target_self;
  logic target_file;

  assign setup = apb_in.psel & ~apb_in.penable;
  assign access = apb_in.psel & apb_in.penable;
  assign direct_id = decode(apb_in.paddr[IDX_W+1:2]);
  assign direct_ok = direct_id != REG_NONE;
  assign eff_addr = {indirect_bank_select, pointer_register}; // see R15
  assign ind_id = decode(eff_addr);
  // The indirect slot holds nothing; it redirects to the pointer.
  assign target_id = (direct_id == REG_INDIRECT) ? ind_id
                                                 : direct_id; // see R12
  assign target_self = (direct_id == REG_INDIRECT) &&
                       (ind_id == REG_INDIRECT);
  assign target_file = (direct_id == REG_INDIRECT) && (ind_id == REG_NONE);

  logic wr_fire;
  // A write through the indirect slot onto itself is dropped.
  assign wr_fire = access & apb_in.pwrite & direct_ok &
                   ~target_self; // see R14
  logic [7:0] wbyte;
  assign wbyte = apb_in.pwdata[7:0];

  assign pready = access;
  assign pslverr = access & ~direct_ok;
  assign file_addr = eff_addr;
  assign file_rd = setup & ~apb_in.pwrite & target_file;
  assign file_wr = wr_fire & target_file;
  assign file_wdata = wbyte;

  logic [7:0] read_value;
  always_comb begin
    read_value = BYTE_ZERO;
    case (target_id)
      REG_INDIRECT: read_value = BYTE_ZERO; // see R13
      REG_PC_LOW: read_value = pc[7:0]; // see R1
      REG_BANK: read_value = {indirect_bank_select, 7'h00};
      REG_POINTER: read_value = pointer_register;
      REG_LATCH: read_value = {3'h0, upper_address_latch};
      REG_RESET_CAUSE: read_value = {6'h00, power_on_flag,
                                     brownout_reset_flag}; // see R16
      REG_IRQ_STATUS: read_value = {5'h00, irq_status};
      REG_IRQ_MASK: read_value = {5'h00, irq_mask};
      REG_NONE: read_value = target_file ? file_rdata : BYTE_ZERO;
      default: read_value = BYTE_ZERO;
    endcase
  end

  // Read data is captured in the setup cycle and shown in access.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= WORD_ZERO;
      read_clear <= EV_ZERO;
    end else if (setup) begin
      prdata <= (apb_in.pwrite || !direct_ok) ? WORD_ZERO
                                              : {24'h000000, read_value};
      read_clear <= (!apb_in.pwrite && target_id == REG_IRQ_STATUS)
                    ? irq_status : EV_ZERO;
    end
  end

  // Software registers; the stack never touches the latch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_address_latch <= LATCH_RESET;
      pointer_register <= BYTE_ZERO;
      indirect_bank_select <= 1'b0;
      irq_mask <= EV_ZERO;
    end else if (core_reset) begin
      upper_address_latch <= LATCH_RESET;
      pointer_register <= BYTE_ZERO;
      indirect_bank_select <= 1'b0;
    end else if (wr_fire) begin
      case (target_id)
        REG_LATCH: upper_address_latch <= wbyte[LATCH_W-1:0]; // see R9
        REG_POINTER: pointer_register <= wbyte;
        REG_BANK: indirect_bank_select <= wbyte[BANK_BIT];
        REG_IRQ_MASK: irq_mask <= wbyte[EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Reset-cause flags: a brown-out event beats a software write to the brown-out flag.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_on_flag <= 1'b0; // see R16
      brownout_reset_flag <= 1'b0; // see R17
    end else begin
      if (wr_fire && target_id == REG_RESET_CAUSE) begin
        power_on_flag <= wbyte[POWER_ON_BIT];
      end
      if (ev_rise[EV_BROWNOUT]) begin
        brownout_reset_flag <= 1'b0; // see R17
      end else if (wr_fire && target_id == REG_RESET_CAUSE) begin
        brownout_reset_flag <= wbyte[BROWNOUT_BIT];
      end
    end
  end

  // Sticky event bits; a new event wins over the read clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= EV_ZERO;
    end else if (access && !apb_in.pwrite) begin
      irq_status <= (irq_status & ~read_clear) | ev_rise;
    end else begin
      irq_status <= irq_status | ev_rise;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Program counter and stack.
  logic [PC_W-1:0] pc_next_seq;
  logic [PC_W-1:0] jump_addr;
  logic [SP_W-1:0] sp_top;
  logic pcl_write;

  assign pc_next_seq = pc + 13'h0001; // see R19
  // Page bit four is ignored, so the top bit of a jump address is always zero.
  assign jump_addr = {1'b0, upper_address_latch[PAGE_LO],
                      core_op.target}; // see R4, R11
  assign sp_top = stack_ptr - 1'b1;
  assign pcl_write = wr_fire && target_id == REG_PC_LOW;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_RESET;
    end else if (core_reset) begin
      pc <= PC_RESET;
    end else if (core_op.ret) begin
      pc <= stack_mem[sp_top]; // see R7
    end else if (core_op.irq) begin
      pc <= INT_VECTOR;
    end else if (core_op.call || core_op.jump) begin
      pc <= jump_addr; // see R4
    end else if (pcl_write) begin
      // The full latch, bit four included, reaches the top bits.
      pc <= {upper_address_latch, wbyte}; // see R2, R3
    end else if (core_op.fetch) begin
      pc <= pc_next_seq; // see R19
    end
  end

  logic do_push;
  logic [PC_W-1:0] push_value;
  assign do_push = !core_reset && !core_op.ret &&
                   (core_op.irq || core_op.call);
  // An interrupt returns to the instruction it pre-empted.
  assign push_value = core_op.irq ? pc : pc_next_seq; // see R6, R19

  // The pointer wraps without any flag; old entries are overwritten.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_ptr <= '0;
    end else if (do_push) begin
      stack_ptr <= stack_ptr + 1'b1; // see R8, R10
    end else if (!core_reset && core_op.ret) begin
      stack_ptr <= sp_top; // see R10
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      stack_mem[stack_ptr] <= push_value; // see R6
    end
  end
endmodule
